// *** flash_region_seq.sv ***
// serial flash slice: resume, suspend limits and security-region commands
// assumes pins reach it unsynchronised; registers over AXI4-Lite on aclk
`timescale 1ns/100ps
`default_nettype none
module flash_region_seq #(
	parameter int unsigned PROG_CYCLES = flash_pkg::PROG_CYCLES_DOC,
	parameter int unsigned ERASE_CYCLES = flash_pkg::ERASE_CYCLES_DOC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import flash_pkg::*;

	if (PROG_CYCLES < 2 || ERASE_CYCLES < 2) begin : g_chk
		$error("operation times must be at least two cycles");
	end

	// ***************************************************
	// pin synchronisers and edge detect
	// ***************************************************
	logic sck_m_q, sck_s_q, sck_p_q, cs_m_q, cs_s_q, cs_p_q;
	logic [3:0] io_m_q, io_s_q;

	// two flops per pin, third stage only for edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{sck_m_q, sck_s_q, sck_p_q} <= 3'h0;
			{cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
			io_m_q <= 4'h0;
			io_s_q <= 4'h0;
		end else begin
			{sck_m_q, sck_s_q, sck_p_q} <= {sck, sck_m_q, sck_s_q};
			{cs_m_q, cs_s_q, cs_p_q} <= {cs_n, cs_m_q, cs_s_q};
			io_m_q <= io_in;
			io_s_q <= io_m_q;
		end
	end

	logic sck_rise, sck_fall, cs_begin, cs_end;
	assign sck_rise = sck_s_q && !sck_p_q && !cs_s_q;
	assign sck_fall = !sck_s_q && sck_p_q && !cs_s_q;
	assign cs_begin = !cs_s_q && cs_p_q;
	assign cs_end = cs_s_q && !cs_p_q;

	// ***************************************************
	// control register fields
	// ***************************************************
	logic [31:0] ctrl_q;
	logic qpi, protect23;
	logic [2:0] alen;
	logic [3:0] dummy, lock;
	assign qpi = ctrl_q[CTRL_QPI];
	assign alen = ctrl_q[CTRL_ADDR4] ? 3'h4 : 3'h3;
	assign dummy = ctrl_q[CTRL_DUMMY_LSB +: 4];
	assign lock = ctrl_q[CTRL_LOCK_LSB +: 4];
	assign protect23 = !ctrl_q[CTRL_LOCKDOWN]
		|| (ctrl_q[CTRL_PW_MODE] && !ctrl_q[CTRL_PW_OK]);

	// ***************************************************
	// command shifter
	// ***************************************************
	logic [7:0] sh_q, sh_nx, op_q;
	logic [2:0] bit_q, bit_nx;
	logic [11:0] byte_idx_q, alen_w;
	logic [31:0] addr_q, addr_nx;
	logic addr_done_q, addr_ok_q, byte_done, rd_after, addr_load;
	logic [3:0] dcnt_q;
	logic [8:0] din_cnt_q;
	logic [7:0] pbuf [0:255];
	logic buf_open;
	seq_t seq_q;
	logic psus_q, esus_q;

	// quad mode takes a nibble per clock, else one bit on io0
	assign sh_nx = qpi ? {sh_q[3:0], io_s_q} : {sh_q[6:0], io_s_q[0]};
	assign bit_nx = qpi ? bit_q + 3'h4 : bit_q + 3'h1;
	assign byte_done = qpi ? (bit_q == 3'h4) : (bit_q == 3'h7);
	assign addr_nx = {addr_q[23:0], sh_nx};
	assign alen_w = {9'h000, alen};
	assign rd_after = (op_q == OP_REGION_READ) && addr_done_q;
	assign addr_load = sck_rise && byte_done && !addr_done_q
		&& byte_idx_q == alen_w;
	assign buf_open = seq_q == SEQ_IDLE && !psus_q;

	// frame capture: opcode, address, dummy count, program data
	always_ff @(posedge aclk) begin
		if (!aresetn || cs_begin) begin
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			byte_idx_q <= 12'h000;
			op_q <= 8'h00;
			addr_q <= 32'h0000_0000;
			addr_done_q <= 1'b0;
			addr_ok_q <= 1'b0;
			dcnt_q <= 4'h0;
			din_cnt_q <= 9'h000;
		end else if (sck_rise && rd_after) begin
			if (dcnt_q != dummy)
				dcnt_q <= dcnt_q + 4'h1;
		end else if (sck_rise) begin
			sh_q <= sh_nx;
			bit_q <= bit_nx;
			if (byte_done) begin
				if (byte_idx_q != 12'hFFF)
					byte_idx_q <= byte_idx_q + 12'h001;
				if (byte_idx_q == 12'h000) begin
					op_q <= sh_nx;
				end else if (!addr_done_q) begin
					addr_q <= addr_nx;
					if (addr_load) begin
						addr_done_q <= 1'b1;
						addr_ok_q <= addr_nx[31:10] == 22'h000000;
					end
				end else if (op_q == OP_REGION_PROGRAM && buf_open) begin
					pbuf[din_cnt_q[7:0] + addr_q[7:0]] <= sh_nx;
					if (!din_cnt_q[8])
						din_cnt_q <= din_cnt_q + 9'h001;
				end
			end
		end
	end

	// ***************************************************
	// read data path
	// ***************************************************
	logic [7:0] mem [0:1023];
	logic [10:0] rd_addr_q;
	logic [7:0] rd_val, out_sh_q;
	logic [2:0] obit_q;
	logic [3:0] io_out_q, io_oe_q;
	logic rd_ph;
	assign rd_ph = rd_after && dcnt_q == dummy;
	// past top, bad address or password-held region 3 reads as ones
	assign rd_val = (!addr_ok_q || rd_addr_q[10]
		|| (rd_addr_q[9:8] == REGION_READ_PW && ctrl_q[CTRL_RD_PW_EN]
		&& !ctrl_q[CTRL_PW_OK])) ? ERASED_BYTE
		: mem[rd_addr_q[9:0]];

	// shift data out on falling sck edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_out_q <= 4'h0;
			io_oe_q <= 4'h0;
			out_sh_q <= 8'h00;
			obit_q <= 3'h0;
			rd_addr_q <= 11'h000;
		end else if (cs_s_q) begin
			io_oe_q <= 4'h0;
			obit_q <= 3'h0;
		end else if (addr_load) begin
			rd_addr_q <= {1'b0, addr_nx[9:0]};
		end else if (sck_fall && rd_ph) begin
			io_oe_q <= qpi ? 4'hF : 4'h2;
			obit_q <= qpi ? obit_q + 3'h4 : obit_q + 3'h1;
			if (obit_q == 3'h0) begin
				io_out_q <= qpi ? rd_val[7:4] : {2'h0, rd_val[7], 1'b0};
				out_sh_q <= qpi ? {rd_val[3:0], 4'h0} : {rd_val[6:0], 1'b0};
				if (!rd_addr_q[10])
					rd_addr_q <= rd_addr_q + 11'h001;
			end else begin
				io_out_q <= qpi ? out_sh_q[7:4] : {2'h0, out_sh_q[7], 1'b0};
				out_sh_q <= qpi ? {out_sh_q[3:0], 4'h0}
					: {out_sh_q[6:0], 1'b0};
			end
		end
	end
	assign io_out = io_out_q;
	assign io_oe = io_oe_q;

	// ***************************************************
	// command decode at chip select release
	// ***************************************************
	logic frame_ok, susp_any, wel_q, sus_cmd, clr_cmd, fail_w;
	logic [1:0] e_reg_q, p_reg_q;
	logic exec_write_enable_cmd, exec_resume, exec_erase, exec_prog, refuse;
	assign frame_ok = cs_end && bit_q == 3'h0;
	assign susp_any = psus_q || esus_q;
	// a region whose erase is suspended cannot take a program
	assign fail_w = !addr_ok_q || lock[addr_q[9:8]]
		|| (addr_q[9] && protect23)
		|| (esus_q && addr_q[9:8] == e_reg_q);
	assign exec_write_enable_cmd = frame_ok && op_q == OP_WRITE_ENABLE
		&& byte_idx_q == 12'h001;
	assign exec_resume = frame_ok && op_q == OP_RESUME
		&& byte_idx_q == 12'h001;
	assign exec_erase = frame_ok && op_q == OP_REGION_ERASE && wel_q
		&& byte_idx_q == alen_w + 12'h001 && seq_q == SEQ_IDLE
		&& !susp_any;
	assign exec_prog = frame_ok && op_q == OP_REGION_PROGRAM && wel_q
		&& byte_idx_q > alen_w + 12'h001 && seq_q == SEQ_IDLE
		&& !psus_q;
	// a whole-byte frame outside the suspend subset is dropped and flagged
	assign refuse = frame_ok && byte_idx_q != 12'h000 && susp_any
		&& !(op_q == OP_WRITE_ENABLE || op_q == OP_RESUME
		|| op_q == OP_REGION_READ
		|| (op_q == OP_REGION_PROGRAM && !psus_q));

	// ***************************************************
	// self-timed sequencer
	// ***************************************************
	logic [31:0] e_cnt_q, p_cnt_q;
	logic [7:0] p_off_q;
	logic [8:0] p_len_q, idx_q;
	logic e_fail_q, p_fail_q, ap_erase_q, e_end, p_end;
	assign e_end = seq_q == SEQ_ERASE && !sus_cmd && e_cnt_q == 32'h0;
	assign p_end = seq_q == SEQ_PROG && !sus_cmd && p_cnt_q == 32'h0;

	// erase and program keep their own timers so they can nest
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_q <= SEQ_IDLE;
			{psus_q, esus_q} <= 2'h0;
			{e_cnt_q, p_cnt_q} <= 64'h0;
			{e_reg_q, p_reg_q, p_off_q, p_len_q} <= 21'h0;
			{e_fail_q, p_fail_q, ap_erase_q} <= 3'h0;
			idx_q <= 9'h000;
		end else begin
			case (seq_q)
			SEQ_IDLE: begin
				if (exec_erase) begin
					seq_q <= SEQ_ERASE;
					e_cnt_q <= 32'(ERASE_CYCLES - 1);
					e_reg_q <= addr_q[9:8];
					e_fail_q <= fail_w;
				end else if (exec_prog) begin
					seq_q <= SEQ_PROG;
					p_cnt_q <= 32'(PROG_CYCLES - 1);
					p_reg_q <= addr_q[9:8];
					p_off_q <= addr_q[7:0];
					p_len_q <= din_cnt_q;
					p_fail_q <= fail_w;
				end else if (exec_resume && psus_q) begin
					seq_q <= SEQ_PROG;
					psus_q <= 1'b0;
				end else if (exec_resume && esus_q) begin
					seq_q <= SEQ_ERASE;
					esus_q <= 1'b0;
				end
			end
			SEQ_ERASE: begin
				if (sus_cmd) begin
					seq_q <= SEQ_IDLE;
					esus_q <= 1'b1;
				end else if (e_end) begin
					seq_q <= e_fail_q ? SEQ_IDLE : SEQ_APPLY;
					ap_erase_q <= 1'b1;
					idx_q <= 9'h000;
				end else begin
					e_cnt_q <= e_cnt_q - 32'h1;
				end
			end
			SEQ_PROG: begin
				if (sus_cmd) begin
					seq_q <= SEQ_IDLE;
					psus_q <= 1'b1;
				end else if (p_end) begin
					seq_q <= p_fail_q ? SEQ_IDLE : SEQ_APPLY;
					ap_erase_q <= 1'b0;
					idx_q <= 9'h000;
				end else begin
					p_cnt_q <= p_cnt_q - 32'h1;
				end
			end
			SEQ_APPLY: begin
				idx_q <= idx_q + 9'h001;
				if (idx_q == (ap_erase_q ? 9'h0FF : p_len_q - 9'h001))
					seq_q <= SEQ_IDLE;
			end
			default: seq_q <= SEQ_IDLE;
			endcase
		end
	end

	// region array update: erase fills ones, program clears bits
	always_ff @(posedge aclk) begin
		if (seq_q == SEQ_APPLY) begin
			if (ap_erase_q)
				mem[{e_reg_q, idx_q[7:0]}] <= ERASED_BYTE;
			else
				mem[{p_reg_q, p_off_q + idx_q[7:0]}] <=
					mem[{p_reg_q, p_off_q + idx_q[7:0]}]
					& pbuf[p_off_q + idx_q[7:0]];
		end
	end

	// ***************************************************
	// status flags, set wins over clear
	// ***************************************************
	logic perr_q, eerr_q, refused_q, wip_w;
	assign wip_w = seq_q != SEQ_IDLE;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{wel_q, perr_q, eerr_q, refused_q} <= 4'h0;
		end else begin
			wel_q <= exec_write_enable_cmd || (wel_q && !exec_erase && !exec_prog);
			eerr_q <= (e_end && e_fail_q) || (eerr_q && !clr_cmd);
			perr_q <= (p_end && p_fail_q) || (perr_q && !clr_cmd);
			refused_q <= refuse || (refused_q && !clr_cmd);
		end
	end

	// ***************************************************
	// AXI4-Lite slave
	// ***************************************************
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, do_write;
	logic [3:0] awaddr_q, wstrb_q;
	logic [31:0] wdata_q, wmask, rdata_q, status_w;
	logic [1:0] bresp_q, rresp_q;
	assign do_write = !awready_q && !wready_q && !bvalid_q;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
		{8{wstrb_q[0]}}};
	assign sus_cmd = do_write && awaddr_q == REG_CMD && wstrb_q[0]
		&& wdata_q[CMD_SUSPEND];
	assign clr_cmd = do_write && awaddr_q == REG_CMD && wstrb_q[0]
		&& wdata_q[CMD_CLEAR];
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[ST_WIP] = wip_w;
		status_w[ST_WEL] = wel_q;
		status_w[ST_PSUS] = psus_q;
		status_w[ST_ESUS] = esus_q;
		status_w[ST_PERR] = perr_q;
		status_w[ST_EERR] = eerr_q;
		status_w[ST_REFUSED] = refused_q;
	end

	// write channels taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{awready_q, wready_q, bvalid_q} <= 3'h6;
			{awaddr_q, wstrb_q, bresp_q} <= 10'h000;
			wdata_q <= 32'h0000_0000;
		end else begin
			if (awvalid && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready_q) begin
				wready_q <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				if (awaddr_q == REG_CTRL || awaddr_q == REG_CMD)
					bresp_q <= RESP_OKAY;
				else
					bresp_q <= RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				{awready_q, wready_q, bvalid_q} <= 3'h6;
			end
		end
	end

	// control register, region lock bits only ever set
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= CTRL_RESET;
		else if (do_write && awaddr_q == REG_CTRL) begin
			ctrl_q <= (((ctrl_q & ~wmask) | (wdata_q & wmask)) & CTRL_MASK)
				| (ctrl_q & (32'h0000_000F << CTRL_LOCK_LSB));
		end
	end

	// read channel, one outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{arready_q, rvalid_q} <= 2'h2;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready_q) begin
			{arready_q, rvalid_q} <= 2'h1;
			if (araddr == REG_CTRL) begin
				rdata_q <= ctrl_q;
				rresp_q <= RESP_OKAY;
			end else if (araddr == REG_STATUS) begin
				rdata_q <= status_w;
				rresp_q <= RESP_OKAY;
			end else begin
				rdata_q <= 32'h0000_0000;
				rresp_q <= RESP_SLVERR;
			end
		end else if (rvalid_q && rready) begin
			{arready_q, rvalid_q} <= 2'h2;
		end
	end
	assign {awready, wready, bvalid, bresp} =
		{awready_q, wready_q, bvalid_q, bresp_q};
	assign {arready, rvalid, rdata, rresp} =
		{arready_q, rvalid_q, rdata_q, rresp_q};

	// ***************************************************
	// assertions
	// ***************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_resume_go;
		exec_resume && susp_any && seq_q == SEQ_IDLE |=> wip_w;
	endproperty
	a_resume_go: assert property (p_resume_go)
		else $error("resume did not restart operation");

	property p_resume_idle;
		exec_resume && !susp_any && !sus_cmd && seq_q == SEQ_IDLE |=>
			$stable({psus_q, esus_q, wel_q, perr_q, eerr_q, seq_q});
	endproperty
	a_resume_idle: assert property (p_resume_idle)
		else $error("idle resume changed state");

	property p_susp_refuse;
		frame_ok && op_q == OP_REGION_ERASE && susp_any
			|=> seq_q != SEQ_ERASE && refused_q;
	endproperty
	a_susp_refuse: assert property (p_susp_refuse)
		else $error("erase accepted during suspend");

	property p_susp_bits;
		(psus_q |-> seq_q != SEQ_PROG) and (esus_q |-> seq_q != SEQ_ERASE);
	endproperty
	a_susp_bits: assert property (p_susp_bits)
		else $error("suspended operation still running");

	property p_back_to_esus;
		p_end && esus_q |-> ##[1:260] (seq_q == SEQ_IDLE && esus_q);
	endproperty
	a_back_to_esus: assert property (p_back_to_esus)
		else $error("nested program did not return to erase suspend");

	property p_lock_erase;
		e_end && lock[e_reg_q] |=> eerr_q && seq_q == SEQ_IDLE;
	endproperty
	a_lock_erase: assert property (p_lock_erase)
		else $error("locked region erase gave no error");

	property p_lock_prog;
		p_end && lock[p_reg_q] |=> perr_q && !wip_w;
	endproperty
	a_lock_prog: assert property (p_lock_prog)
		else $error("locked region program gave no error");

	property p_r23_block;
		exec_erase && addr_q[9] && !ctrl_q[CTRL_LOCKDOWN] |=> e_fail_q;
	endproperty
	a_r23_block: assert property (p_r23_block)
		else $error("region 2 or 3 erase not blocked");

	property p_pw_block;
		exec_prog && addr_q[9] && ctrl_q[CTRL_PW_MODE]
			&& !ctrl_q[CTRL_PW_OK] |=> p_fail_q;
	endproperty
	a_pw_block: assert property (p_pw_block)
		else $error("password-held region program not blocked");

	property p_busy_hold;
		exec_prog |=> wip_w [*2];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy flag dropped early");

	property p_wel_need;
		$rose(seq_q == SEQ_ERASE) && !$past(esus_q) |-> $past(wel_q);
	endproperty
	a_wel_need: assert property (p_wel_need)
		else $error("erase started without write enable");

	property p_partial;
		cs_end && byte_idx_q == 12'h000 |=> $stable({psus_q, esus_q});
	endproperty
	a_partial: assert property (p_partial)
		else $error("partial command changed suspend state");

	c_resume_prog: cover property (exec_resume && psus_q);
	c_nested_prog: cover property (p_end && esus_q);
	c_erase_err: cover property (e_end && e_fail_q);

endmodule
`default_nettype wire

// *** flash_pkg.sv ***
// constants, field positions and types of the region sequencer
// assumes a single 25 MHz clock and a host that owns chip select and sck
package flash_pkg;

	// ***************************************************
	// opcodes
	// ***************************************************
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_REGION_ERASE = 8'h44;
	localparam logic [7:0] OP_REGION_PROGRAM = 8'h42;
	localparam logic [7:0] OP_REGION_READ = 8'h48;

	// ***************************************************
	// register map and fields
	// ***************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CMD = 4'h8;
	localparam int CTRL_QPI = 0;
	localparam int CTRL_ADDR4 = 1;
	localparam int CTRL_DUMMY_LSB = 2;
	localparam int CTRL_LOCKDOWN = 6;
	localparam int CTRL_PW_MODE = 7;
	localparam int CTRL_RD_PW_EN = 8;
	localparam int CTRL_PW_OK = 9;
	localparam int CTRL_LOCK_LSB = 10;
	localparam int CTRL_QE = 14;
	localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam int ST_PSUS = 8;
	localparam int ST_ESUS = 9;
	localparam int ST_PERR = 13;
	localparam int ST_EERR = 14;
	localparam int ST_REFUSED = 16;
	localparam int CMD_SUSPEND = 0;
	localparam int CMD_CLEAR = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ***************************************************
	// region space and timing
	// ***************************************************
	localparam logic [1:0] REGION_READ_PW = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int CLK_PERIOD_NS = 40;
	localparam int PROG_TIME_NS = 500000;
	localparam int ERASE_TIME_NS = 50000000;
	localparam int PROG_CYCLES_DOC = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ERASE_CYCLES_DOC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ERASE = 2'b01,
		SEQ_PROG = 2'b10,
		SEQ_APPLY = 2'b11
	} seq_t;

endpackage

// *** flash_host_model.sv ***
// host side of the serial link: frames, address, data, read capture
// assumes aclk from the bench; sck period 8 aclk, 5 low and 3 high
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
	input wire logic aclk,
	output logic cs_n,
	output logic sck,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out
);
	// idle link: deselected, clock parked low, wp and hold high
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		io_in = 4'hF;
	end
	// one sck period: drive on the fall, sample just before the rise
	task automatic bit1(input logic b, output logic s);
		@(posedge aclk);
		sck <= 1'b0;
		io_in[0] <= b;
		repeat (5) @(posedge aclk);
		s = io_out[1];
		sck <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask
	// opcode msbs, address, one write byte, then read bytes
	task automatic xfer(input logic [7:0] op, input int opbits,
		input int na, input logic [23:0] ad, input int nw,
		input logic [7:0] wd, input int nr, output logic [7:0] rd);
		logic s;
		@(posedge aclk);
		cs_n <= 1'b0;
		for (int i = 7; i > 7 - opbits; i--) bit1(op[i], s);
		for (int i = 23; i >= 24 - na * 8; i--) bit1(ad[i], s);
		for (int i = 7; i >= 8 - nw * 8; i--) bit1(wd[i], s);
		rd = 8'h00;
		for (int i = 0; i < nr * 8; i++) begin
			bit1(1'b1, s);
			rd = {rd[6:0], s};
		end
		@(posedge aclk);
		sck <= 1'b0;
		repeat (2) @(posedge aclk);
		cs_n <= 1'b1;
		io_in[0] <= ~io_in[0]; // released line shows no stale level
		repeat (8) @(posedge aclk);
	endtask
	// quad frame of one opcode, a nibble per sck, upper first
	task automatic qop(input logic [7:0] op);
		logic s;
		@(posedge aclk);
		cs_n <= 1'b0;
		for (int i = 1; i >= 0; i--) begin
			io_in <= op[i * 4 +: 4];
			bit1(op[i * 4], s);
		end
		@(posedge aclk);
		sck <= 1'b0;
		repeat (2) @(posedge aclk);
		cs_n <= 1'b1;
		io_in <= 4'hF;
		repeat (8) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// *** flash_region_seq_tb_top.sv ***
// bench for the region sequencer: registers, resume, region commands
// assumes flash_pkg and flash_host_model; short op timers
`timescale 1ns/100ps
`default_nettype none
module flash_region_seq_tb_top;
	import flash_pkg::*;
	typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [1:0] r;} row_t;
	localparam logic [31:0] QE = 32'h0000_4000;
	logic aclk, aresetn, cs_n, sck, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] host_io, io_in, io_out, io_oe, awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] rb;
	int n_mismatch, cmp_count;
	row_t rows [7];
	// pin level: device where enabled, host elsewhere
	assign io_in = (io_oe & io_out) | (~io_oe & host_io);
	flash_region_seq #(.PROG_CYCLES(40), .ERASE_CYCLES(80)) dut_u (.aclk,
		.aresetn, .cs_n, .sck, .io_in, .io_out, .io_oe, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	flash_host_model host_u (.aclk, .cs_n, .sck, .io_in(host_io),
		.io_out(io_in));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write: address and data together, each released when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic b;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hF};
		{awvalid, wvalid, bready} <= 3'h7;
		b = 1'b0;
		while (!b) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				b = 1'b1;
				resp = bresp;
				bready <= 1'b0;
			end
		end
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		logic b;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		b = 1'b0;
		while (!b) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				b = 1'b1;
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
			end
		end
	endtask
	task automatic st(input logic [31:0] e);
		axi_rd(REG_STATUS, v);
		chk("status", e, v);
	endtask
	task automatic wait_idle;
		do axi_rd(REG_STATUS, v); while (v[ST_WIP] !== 1'b0);
	endtask
	task automatic cmd(input logic [7:0] op);
		host_u.xfer(op, 8, 0, 24'h0, 0, 8'h00, 0, rb);
	endtask
	task automatic cmda(input logic [7:0] op, input logic [23:0] ad);
		host_u.xfer(op, 8, 3, ad, int'(op == OP_REGION_PROGRAM), 8'h00, 0, rb);
	endtask
	// enabled op under a protection setting, then its error flags
	task automatic op_case(input logic [31:0] c, input logic [7:0] op,
		input logic [23:0] ad, input logic [31:0] e);
		axi_wr(REG_CTRL, c);
		cmd(OP_WRITE_ENABLE);
		cmda(op, ad);
		wait_idle();
		st(e);
		axi_wr(REG_CMD, 32'h0000_0002);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog well past the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		rows = '{'{0, REG_CTRL, 0, RESP_OKAY}, '{0, REG_STATUS, 0, RESP_OKAY},
			'{0, 4'hC, 0, RESP_SLVERR}, '{1, REG_STATUS, 1, RESP_SLVERR},
			'{1, 4'hC, 1, RESP_SLVERR}, '{1, REG_CTRL, 32'hFFFF_8004, RESP_OKAY},
			'{0, REG_CTRL, 32'h0000_0004, RESP_OKAY}};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		// register table rows: response code and read value
		foreach (rows[i]) begin
			if (rows[i].w) axi_wr(rows[i].a, rows[i].d);
			else axi_rd(rows[i].a, v);
			chk("resp", {30'h0, rows[i].r}, {30'h0, resp});
			if (!rows[i].w) chk("rdata", rows[i].d, v);
		end
		axi_wr(REG_CTRL, QE);
		cmd(OP_RESUME);
		st(32'h0);
		cmda(OP_REGION_ERASE, 24'h0);
		st(32'h0);
		cmd(OP_WRITE_ENABLE);
		st(32'h2);
		cmda(OP_REGION_ERASE, 24'h0);
		st(32'h1);
		axi_wr(REG_CMD, 32'h1);
		st(32'h200);
		cmd(8'h01);
		st(32'h1_0200);
		host_u.xfer(OP_RESUME, 4, 0, 24'h0, 0, 8'h00, 0, rb);
		st(32'h1_0200);
		cmd(OP_WRITE_ENABLE);
		cmda(OP_REGION_PROGRAM, 24'h000100);
		wait_idle();
		st(32'h1_0200);
		cmd(OP_WRITE_ENABLE);
		cmda(OP_REGION_PROGRAM, 24'h0);
		wait_idle();
		st(32'h1_2200);
		cmd(OP_RESUME);
		st(32'h1_2001);
		wait_idle();
		axi_wr(REG_CMD, 32'h2);
		st(32'h0);
		host_u.xfer(OP_REGION_READ, 8, 3, 24'h0, 0, 8'h00, 2, rb);
		chk("read byte 1", 32'hFF, {24'h0, rb});
		// eight dummy clocks, then region 1 byte 0 as programmed
		axi_wr(REG_CTRL, QE | 32'h20);
		host_u.xfer(OP_REGION_READ, 8, 3, 24'h000100, 0, 8'h00, 2, rb);
		chk("read region 1", 32'h0, {24'h0, rb});
		chk("io_oe idle", 32'h0, {28'h0, io_oe});
		// program suspend: program and erase refused, quad resume
		cmd(OP_WRITE_ENABLE);
		cmda(OP_REGION_PROGRAM, 24'h000020);
		axi_wr(REG_CMD, 32'h1);
		st(32'h100);
		cmd(OP_WRITE_ENABLE);
		cmda(OP_REGION_PROGRAM, 24'h000010);
		cmda(OP_REGION_ERASE, 24'h0);
		st(32'h1_0102);
		axi_wr(REG_CTRL, QE | 32'h1);
		host_u.qop(OP_RESUME);
		st(32'h1_0003);
		axi_wr(REG_CTRL, QE);
		wait_idle();
		axi_wr(REG_CMD, 32'h2);
		op_case(QE, OP_REGION_PROGRAM, 24'h000010, 32'h0);
		op_case(QE, OP_REGION_ERASE, 24'h000200, 32'h4000);
		op_case(QE, OP_REGION_PROGRAM, 24'h000300, 32'h2000);
		op_case(QE | 32'hC0, OP_REGION_ERASE, 24'h000300, 32'h4000);
		op_case(QE | 32'h2C0, OP_REGION_PROGRAM, 24'h000200, 32'h0);
		op_case(QE | 32'h800, OP_REGION_ERASE, 24'h000100, 32'h4000);
		op_case(QE | 32'h800, OP_REGION_PROGRAM, 24'h000100, 32'h2000);
		report_and_stop();
	end
endmodule
`default_nettype wire
